/* core/fault_retry_pkg.sv */
// constants, types and register map of the fault auto-retry controller
package fault_retry_pkg;
    // timing: clock, ramp discharge pulse, retry delay and quiet interval
    localparam int CLK_PERIOD_NS = 50;
    localparam int DISCHARGE_TIME_NS = 200;
    localparam int DISCHARGE_CYCLES = (DISCHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DELAY_RAMPS = 128;
    localparam int QUIET_DELAYS = 7;
    localparam int QUIET_RAMPS = QUIET_DELAYS * DELAY_RAMPS;
    // retry count derivation
    localparam int RATIO_GAIN = 4;
    localparam int DEFAULT_RETRIES = 4;
    localparam int LEVEL_STEP = 4;
    localparam int LEVEL_COUNT = 5;
    localparam int MAX_RETRIES = 1024;
    localparam int COUNT_W = 11;
    // register map, byte addresses
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_EVENT = 8'h08;
    localparam logic [7:0] ADDR_EVENT_CLR = 8'h0C;
    localparam logic [7:0] ADDR_EVENT_EN = 8'h10;
    localparam logic CTRL_RESET = 1'h1;
    // status fields
    localparam int STATUS_PHASE_LSB = 0;
    localparam int STATUS_RETRY_LSB = 8;
    localparam int STATUS_LIMIT_LSB = 20;
    localparam int STATUS_UNLIMITED_BIT = 31;
    // event bits
    localparam int EVENT_W = 5;
    localparam int EV_LATCH = 0;
    localparam int EV_RETRY = 1;
    localparam int EV_LOCKOUT = 2;
    localparam int EV_HANDSHAKE = 3;
    localparam int EV_COUNT_CLR = 4;
    localparam logic [EVENT_W-1:0] EVENT_EN_RESET = 5'h00;

    typedef enum logic [4:0] {
        PH_OFF = 5'b00001,
        PH_MEASURE = 5'b00010,
        PH_RUN = 5'b00100,
        PH_WAIT = 5'b01000,
        PH_LATCHED = 5'b10000
    } phase_type;

    typedef struct packed {
        logic over_temperature;
        logic breaker_trip;
        logic blanking_timer_grounded;
        logic current_limit_grounded;
    } fault_cause_type;

    typedef struct packed {
        logic delay_grounded;
        logic delay_ramp_top;
        logic count_grounded;
        logic count_open;
        logic count_ramp_top;
    } strap_sense_type;
endpackage

/* core/ramp_tracker.sv */
// strap ramp oscillator: counts one period per crossing and discharges the pin
module ramp_tracker
    import fault_retry_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // comparator side
    input wire logic run,
    input wire logic ramp_top,
    // results
    output logic discharge,
    output logic period_done
);
    localparam int CNT_W = $clog2(DISCHARGE_CYCLES + 1);

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic armed;
        logic discharge;
        logic period_done;
    } ramp_state_type;

    ramp_state_type state_reg;
    ramp_state_type state_next;

    always_comb begin
        state_next = state_reg;
        state_next.period_done = 1'b0;
        if (!run) begin
            // a stopped ramp may sit at its top; without this the start would never arm
            state_next = '0;
            state_next.armed = 1'b1;
        end else if (state_reg.discharge) begin
            state_next.count = state_reg.count - CNT_W'(1);
            if (state_reg.count == CNT_W'(1)) begin
                state_next.discharge = 1'b0;
            end
        end else if (!ramp_top) begin
            // re-arm only once the comparator has dropped, so one crossing is one period
            state_next.armed = 1'b1;
        end else if (state_reg.armed) begin
            state_next.armed = 1'b0;
            state_next.discharge = 1'b1;
            state_next.count = CNT_W'(DISCHARGE_CYCLES);
            state_next.period_done = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign discharge = state_reg.discharge;
    assign period_done = state_reg.period_done;
endmodule

/* core/retry_limit_quantizer.sv */
// turns a measured ramp ratio into a retry limit on the fixed level ladder
module retry_limit_quantizer
    import fault_retry_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // measurement
    input wire logic load,
    input wire logic [COUNT_W-1:0] ratio,
    // result
    output logic [COUNT_W-1:0] limit
);
    typedef struct packed {
        logic [COUNT_W-1:0] limit;
    } quant_state_type;

    quant_state_type state_reg;
    quant_state_type state_next;
    logic [COUNT_W+1:0] nominal;

    function automatic logic [COUNT_W-1:0] round_up_level(input logic [COUNT_W+1:0] value);
        logic [COUNT_W-1:0] level;
        logic [COUNT_W-1:0] pick;
        level = COUNT_W'(MAX_RETRIES);
        pick = COUNT_W'(MAX_RETRIES);
        // walk down the ladder; the last level still at or above the value wins
        for (int i = 0; i < LEVEL_COUNT; i++) begin
            if (value <= (COUNT_W + 2)'(level)) begin
                pick = level;
            end
            level = level / COUNT_W'(LEVEL_STEP);
        end
        return pick;
    endfunction

    assign nominal = (COUNT_W + 2)'(RATIO_GAIN) * {2'b00, ratio};

    always_comb begin
        state_next = state_reg;
        if (load) begin
            state_next.limit = round_up_level(nominal);
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg.limit <= COUNT_W'(DEFAULT_RETRIES);
        end else begin
            state_reg <= state_next;
        end
    end

    assign limit = state_reg.limit;

    chk_limit_on_ladder: assert property (@(posedge core_clk) disable iff (!reset_n)
        load |=> (limit == 11'h004 || limit == 11'h010 || limit == 11'h040
                  || limit == 11'h100 || limit == 11'h400))
        else $error("retry limit is not a ladder level");

    chk_limit_covers: assert property (@(posedge core_clk) disable iff (!reset_n)
        load |=> ((COUNT_W + 2)'(limit) >= $past(nominal) || limit == 11'h400)
                 && ((COUNT_W + 2)'(limit >> 4) < $past(nominal) || limit == 11'h004))
        else $error("retry limit does not round the nominal count up");
endmodule

/* core/fault_auto_retry_controller.sv */
// fault latch, strap decoding, auto-retry sequencing, handshake gating and APB registers
//
// Design decisions made here: the APB slave port and the placing of the registers.
module fault_auto_retry_controller
    import fault_retry_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // supply and enable sensing
    input wire logic enable_undervoltage_input,
    input wire logic supply_undervoltage,
    input wire logic gate_charged,
    // fault causes and straps
    input wire fault_cause_type fault_cause,
    input wire strap_sense_type strap_sense,
    // load handshake comparator, high while above threshold
    input wire logic load_handshake_input,
    // switch and status pins
    output logic switch_on,
    output logic power_good_output,
    output logic fault_latched,
    output logic handshake_fault,
    output logic retry_delay_strap_discharge,
    output logic retry_count_strap_discharge,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt
    output logic irq
);
    localparam int WAIT_W = $clog2(DELAY_RAMPS);
    localparam int QUIET_W = $clog2(QUIET_RAMPS);
    localparam logic [WAIT_W-1:0] WAIT_LAST = WAIT_W'(DELAY_RAMPS - 1);
    localparam logic [QUIET_W-1:0] QUIET_LAST = QUIET_W'(QUIET_RAMPS - 1);

    typedef struct packed {
        phase_type phase;
        logic latch_only;
        logic unlimited;
        logic count_from_cap;
        logic measuring;
        logic [WAIT_W-1:0] wait_cnt;
        logic [QUIET_W-1:0] quiet_cnt;
        logic [COUNT_W-1:0] retry_cnt;
        logic [COUNT_W-1:0] ratio_cnt;
        logic fault_latched;
        logic handshake_fault;
        logic switch_on;
        logic power_good;
        logic sw_enable;
        logic [EVENT_W-1:0] events;
        logic [EVENT_W-1:0] event_en;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
    } ctrl_state_type;

    ctrl_state_type state_reg;
    ctrl_state_type state_next;

    logic delay_done;
    logic count_done;
    logic quant_load;
    logic [COUNT_W-1:0] quant_limit;
    logic [COUNT_W-1:0] eff_limit;
    logic enabled;
    logic fault_any;
    logic exhausted;
    logic commit;

    function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
        return addr == ADDR_CTRL || addr == ADDR_STATUS || addr == ADDR_EVENT
            || addr == ADDR_EVENT_CLR || addr == ADDR_EVENT_EN;
    endfunction

    // the delay oscillator runs whenever enabled, except in latch-only mode, so the quiet interval keeps time
    ramp_tracker delay_ramp (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .run(state_reg.phase != PH_OFF && !state_reg.latch_only),
        .ramp_top(strap_sense.delay_ramp_top),
        .discharge(retry_delay_strap_discharge),
        .period_done(delay_done)
    );

    ramp_tracker count_ramp (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .run(state_reg.phase == PH_MEASURE),
        .ramp_top(strap_sense.count_ramp_top),
        .discharge(retry_count_strap_discharge),
        .period_done(count_done)
    );

    retry_limit_quantizer quantizer (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .load(quant_load),
        .ratio(state_reg.ratio_cnt),
        .limit(quant_limit)
    );

    assign enabled = enable_undervoltage_input && !supply_undervoltage && state_reg.sw_enable;
    assign fault_any = |fault_cause;
    assign quant_load = state_reg.phase == PH_MEASURE && state_reg.measuring && count_done;
    assign eff_limit = state_reg.count_from_cap ? quant_limit : COUNT_W'(DEFAULT_RETRIES);
    assign exhausted = !state_reg.unlimited && state_reg.retry_cnt >= eff_limit;
    assign commit = psel && penable && state_reg.pready;

    always_comb begin
        logic [EVENT_W-1:0] ev;
        logic [EVENT_W-1:0] clr;
        ev = '0;
        clr = '0;
        state_next = state_reg;
        state_next.pready = 1'b0;
        state_next.pslverr = 1'b0;

        // quiet interval since the last fault, held at its end
        if (fault_any) begin
            state_next.quiet_cnt = '0;
        end else if (delay_done && state_reg.quiet_cnt != QUIET_LAST) begin
            state_next.quiet_cnt = state_reg.quiet_cnt + QUIET_W'(1);
        end

        case (state_reg.phase)
            PH_OFF: begin
                if (enabled) begin
                    // straps are caught at the enabling edge and held while enabled
                    state_next.latch_only = strap_sense.delay_grounded;
                    state_next.unlimited = strap_sense.count_grounded;
                    state_next.count_from_cap = !strap_sense.count_grounded
                                                && !strap_sense.count_open;
                    state_next.phase = (!strap_sense.count_grounded && !strap_sense.count_open)
                                       ? PH_MEASURE : PH_RUN;
                end
            end
            PH_MEASURE: begin
                if (fault_any) begin
                    state_next.fault_latched = 1'b1;
                    ev[EV_LATCH] = !state_reg.fault_latched;
                end
                if (state_reg.measuring && delay_done && state_reg.ratio_cnt != '1) begin
                    state_next.ratio_cnt = state_reg.ratio_cnt + COUNT_W'(1);
                end
                if (count_done) begin
                    if (state_reg.measuring) begin
                        state_next.measuring = 1'b0;
                        state_next.wait_cnt = '0;
                        if (!state_next.fault_latched) begin
                            state_next.phase = PH_RUN;
                        end else if (state_reg.latch_only) begin
                            state_next.phase = PH_LATCHED;
                        end else begin
                            state_next.phase = PH_WAIT;
                        end
                    end else begin
                        state_next.measuring = 1'b1;
                        state_next.ratio_cnt = '0;
                    end
                end
            end
            PH_RUN: begin
                if (fault_any) begin
                    state_next.fault_latched = 1'b1;
                    state_next.wait_cnt = '0;
                    ev[EV_LATCH] = 1'b1;
                    if (state_reg.latch_only) begin
                        state_next.phase = PH_LATCHED;
                        ev[EV_LOCKOUT] = 1'b1;
                    end else begin
                        state_next.phase = PH_WAIT;
                    end
                end else if (delay_done && state_reg.quiet_cnt == QUIET_LAST
                             && state_reg.retry_cnt != '0) begin
                    state_next.retry_cnt = '0;
                    ev[EV_COUNT_CLR] = 1'b1;
                end
            end
            PH_WAIT: begin
                if (delay_done) begin
                    if (state_reg.wait_cnt == WAIT_LAST) begin
                        if (exhausted) begin
                            state_next.phase = PH_LATCHED;
                            ev[EV_LOCKOUT] = 1'b1;
                        end else begin
                            state_next.retry_cnt = state_reg.retry_cnt + COUNT_W'(1);
                            state_next.fault_latched = 1'b0;
                            state_next.phase = PH_RUN;
                            ev[EV_RETRY] = 1'b1;
                        end
                    end else begin
                        state_next.wait_cnt = state_reg.wait_cnt + WAIT_W'(1);
                    end
                end
            end
            PH_LATCHED: begin
                state_next.fault_latched = 1'b1;
            end
            default: begin
                state_next.phase = PH_OFF;
            end
        endcase

        // handshake: pulled low by the load releases the fault
        if (!load_handshake_input) begin
            state_next.handshake_fault = 1'b0;
        end
        if (state_reg.power_good && load_handshake_input) begin
            state_next.handshake_fault = 1'b1;
            ev[EV_HANDSHAKE] = !state_reg.handshake_fault;
        end

        // supply or enable shutdown is the external latch reset
        if (!enabled) begin
            state_next.phase = PH_OFF;
            state_next.fault_latched = 1'b0;
            state_next.handshake_fault = 1'b0;
            state_next.retry_cnt = '0;
            state_next.wait_cnt = '0;
            state_next.measuring = 1'b0;
        end

        state_next.switch_on = state_next.phase == PH_RUN && !fault_any
                               && !load_handshake_input
                               && !state_next.handshake_fault;
        state_next.power_good = state_reg.switch_on && state_next.switch_on && gate_charged;

        // APB: pready rises one cycle into the access phase; writes land at the next edge, while pready is high
        if (psel && penable && !state_reg.pready) begin
            state_next.pready = 1'b1;
            state_next.pslverr = !is_mapped(paddr);
            state_next.prdata = '0;
            if (!pwrite) begin
                case (paddr)
                    ADDR_CTRL: state_next.prdata[0] = state_reg.sw_enable;
                    ADDR_STATUS: begin
                        state_next.prdata[STATUS_PHASE_LSB +: 5] = state_reg.phase;
                        state_next.prdata[STATUS_RETRY_LSB +: COUNT_W] = state_reg.retry_cnt;
                        state_next.prdata[STATUS_LIMIT_LSB +: COUNT_W] = eff_limit;
                        state_next.prdata[STATUS_UNLIMITED_BIT] = state_reg.unlimited;
                    end
                    ADDR_EVENT: state_next.prdata[EVENT_W-1:0] = state_reg.events;
                    ADDR_EVENT_EN: state_next.prdata[EVENT_W-1:0] = state_reg.event_en;
                    default: state_next.prdata = '0;
                endcase
            end
        end
        if (commit && pwrite) begin
            case (paddr)
                ADDR_CTRL: state_next.sw_enable = pwdata[0];
                ADDR_EVENT_CLR: clr = pwdata[EVENT_W-1:0];
                ADDR_EVENT_EN: state_next.event_en = pwdata[EVENT_W-1:0];
                default: clr = '0;
            endcase
        end
        // a new event in the clearing cycle survives the clear
        state_next.events = (state_reg.events & ~clr) | ev;
        state_next.irq = |(state_next.events & state_next.event_en);
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= '0;
            state_reg.phase <= PH_OFF;
            state_reg.sw_enable <= CTRL_RESET;
            state_reg.event_en <= EVENT_EN_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign switch_on = state_reg.switch_on;
    assign power_good_output = state_reg.power_good;
    assign fault_latched = state_reg.fault_latched;
    assign handshake_fault = state_reg.handshake_fault;
    assign prdata = state_reg.prdata;
    assign pready = state_reg.pready;
    assign pslverr = state_reg.pslverr;
    assign irq = state_reg.irq;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_wait_expires;
        state_reg.phase == PH_WAIT && delay_done && state_reg.wait_cnt == WAIT_LAST && enabled;
    endsequence

    sequence s_fault_in_run;
        state_reg.phase == PH_RUN && fault_any && enabled;
    endsequence

    chk_disable_off: assert property (
        !enable_undervoltage_input |=> !switch_on && !power_good_output)
        else $error("switch on while enable is low");

    chk_handshake_gate: assert property (
        load_handshake_input |=> !switch_on)
        else $error("switch on while handshake is high");

    chk_latch_reset: assert property (
        (supply_undervoltage || !enable_undervoltage_input) |=> !fault_latched
                                                                && state_reg.retry_cnt == '0)
        else $error("fault latch survived an external reset");

    chk_fault_latches: assert property (
        s_fault_in_run |=> fault_latched && !switch_on)
        else $error("fault did not latch the switch off");

    chk_latch_only: assert property (
        s_fault_in_run ##0 state_reg.latch_only |=> state_reg.phase == PH_LATCHED)
        else $error("latch-only mode did not latch off");

    chk_retry_delay: assert property (
        (state_reg.phase == PH_RUN && $past(state_reg.phase) == PH_WAIT)
            |-> $past(state_reg.wait_cnt) == WAIT_LAST)
        else $error("retry left the wait before its ramp periods");

    chk_retry_limit: assert property (
        s_wait_expires ##0 exhausted |=> state_reg.phase == PH_LATCHED && fault_latched)
        else $error("retry attempted past the limit");

    chk_retry_clears: assert property (
        s_wait_expires ##0 !exhausted |=> state_reg.phase == PH_RUN && !fault_latched
            && state_reg.retry_cnt == $past(state_reg.retry_cnt) + 11'h001)
        else $error("retry did not clear the latch and count");

    chk_default_four: assert property (
        (state_reg.phase != PH_OFF && !state_reg.count_from_cap && !state_reg.unlimited)
            |-> eff_limit == 11'h004)
        else $error("open count strap does not give four retries");

    chk_quiet_clear: assert property (
        state_reg.phase == PH_RUN && enabled && !fault_any && delay_done
            && state_reg.quiet_cnt == QUIET_LAST |=> state_reg.retry_cnt == '0)
        else $error("retry count not cleared after the quiet interval");

    chk_handshake_fault: assert property (
        power_good_output && load_handshake_input && enabled
            |=> handshake_fault && !switch_on)
        else $error("handshake timeout did not flag a fault");
endmodule

/* bench/strap_ramp_model.sv */
// strap capacitor ramp seen by the comparator, reset by the discharge pulse
module strap_ramp_model (
    // pins
    input wire logic core_clk,
    input wire logic discharge,
    input wire logic [3:0] charge_cycles,
    output logic ramp_top
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] level = 4'h0;
    // a larger strap capacitor means more charge cycles per period
    always @(posedge core_clk) begin
        if (discharge) begin
            level <= 4'h0;
        end else if (level < charge_cycles) begin
            level <= level + 4'h1;
        end
    end
    assign ramp_top = (level >= charge_cycles) && !discharge;
endmodule

/* bench/tb_fault_auto_retry_controller.sv */
// self-checking bench of the fault auto-retry controller
module tb_fault_auto_retry_controller;
    import fault_retry_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 0, reset_n = 0, en = 0, hs = 0, dgnd = 0, cgnd = 0, copen = 1;
    logic psel = 0, penable = 0, pwrite = 0, dtop, ctop, sw, fl, ddis, cdis, pready, irq;
    logic uv = 0, hf, pg, perr, qe;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q, lf = 32'h2C26;
    logic [3:0] chg = 4'h3;
    fault_cause_type fault_cause = '0;
    strap_sense_type strap_sense;
    int error_cnt = 0, total_checks = 0, ramps = 0;
    always #25 core_clk = ~core_clk;
    always @(posedge ddis) ramps++;
    assign strap_sense = '{dgnd, dtop, cgnd, copen, ctop};
    fault_auto_retry_controller fault_auto_retry_controller_inst (.core_clk(core_clk),
        .reset_n(reset_n), .enable_undervoltage_input(en), .supply_undervoltage(uv),
        .gate_charged(1'b1), .fault_cause(fault_cause), .strap_sense(strap_sense),
        .load_handshake_input(hs), .switch_on(sw), .power_good_output(pg), .fault_latched(fl),
        .handshake_fault(hf), .retry_delay_strap_discharge(ddis),
        .retry_count_strap_discharge(cdis), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(perr),
        .irq(irq));
    strap_ramp_model dly_inst (.core_clk(core_clk), .discharge(ddis), .charge_cycles(chg),
        .ramp_top(dtop));
    // the count strap carries the larger capacitor
    strap_ramp_model cnt_inst (.core_clk(core_clk), .discharge(cdis), .charge_cycles(4'hF),
        .ramp_top(ctop));
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // delay crossings inside one count period, times the gain, rounded up the ladder
    function automatic logic [10:0] exp_limit(input int cd, input int cc);
        int n;
        n = RATIO_GAIN * ((cc + DISCHARGE_CYCLES) / (cd + DISCHARGE_CYCLES + 1));
        exp_limit = 11'h004;
        while (exp_limit < n)
            exp_limit = exp_limit * 11'h004;
    endfunction
    task stop_test;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            error_cnt++;
            stop_test();
        end
        q = prdata;
        qe = perr;
        psel <= 0;
        penable <= 0;
    endtask
    task wait_sw(input logic v);
        int n;
        n = 0;
        while (sw !== v && n < 4000) begin
            @(posedge core_clk);
            n++;
        end
        if (sw !== v) begin
            error_cnt++;
            stop_test();
        end
    endtask
    // one-cycle fault of a random cause, with a random ramp period
    task hit;
        @(posedge core_clk);
        lf = nxt(lf);
        fault_cause <= fault_cause_type'(lf[3:0] | 4'h1);
        chg <= 4'h2 + {2'b00, lf[5:4]};
        @(posedge core_clk);
        fault_cause <= '0;
        ramps = 0;
        @(posedge core_clk);
        check(fl, 1);
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        reset_n <= 1;
        apb(0, ADDR_STATUS, 0);
        check(q[4:0], 5'h01);
        en <= 1;
        wait_sw(1);
        repeat (2) @(posedge core_clk);
        check(pg, 1);
        hs <= 1;
        repeat (3) @(posedge core_clk);
        check({sw, hf}, 2'b01);
        hs <= 0;
        wait_sw(1);
        $display("test handshake done");
        apb(1, ADDR_EVENT_EN, 32'h4);
        for (int i = 0; i < 5; i++) begin
            hit();
            if (i < 4) begin
                wait_sw(1);
                check(ramps, DELAY_RAMPS);
            end
        end
        repeat (2500) @(posedge core_clk);
        check(sw, 0);
        apb(0, ADDR_STATUS, 0);
        check({q[18:8], q[4:0]}, {11'd4, 5'h10});
        check(irq, 1);
        apb(1, ADDR_EVENT_CLR, 32'h4);
        repeat (2) @(posedge core_clk);
        check(irq, 0);
        $display("test four retries done");
        en <= 0;
        cgnd <= 1;
        copen <= 0;
        repeat (3) @(posedge core_clk);
        check(fl, 0);
        en <= 1;
        wait_sw(1);
        for (int i = 0; i < 6; i++) begin
            hit();
            wait_sw(1);
        end
        apb(0, ADDR_STATUS, 0);
        check({q[31], q[18:8]}, {1'b1, 11'd6});
        // long enough for the quiet interval even at the slowest random ramp
        repeat (10000) @(posedge core_clk);
        apb(0, ADDR_STATUS, 0);
        check(q[18:8], 11'd0);
        $display("test unlimited done");
        en <= 0;
        dgnd <= 1;
        repeat (3) @(posedge core_clk);
        en <= 1;
        wait_sw(1);
        hit();
        repeat (2000) @(posedge core_clk);
        apb(0, ADDR_STATUS, 0);
        check({sw, q[4:0]}, {1'b0, 5'h10});
        uv <= 1;
        repeat (3) @(posedge core_clk);
        check(fl, 0);
        $display("test latch off done");
        uv <= 0;
        en <= 0;
        dgnd <= 0;
        cgnd <= 0;
        chg <= 4'h2;
        repeat (3) @(posedge core_clk);
        en <= 1;
        wait_sw(1);
        apb(0, ADDR_STATUS, 0);
        check(q[30:20], exp_limit(2, 15));
        apb(0, 8'h14, 0);
        check({qe, q[30:0]}, 32'h80000000);
        $display("test measured limit done");
        stop_test();
    end
endmodule
